// ### src/rsw_pkg.sv
package rsw_pkg;
	localparam int RSW_POR_SHORT_CYC = 128;
	localparam int RSW_POR_LONG_CYC = 4064;
	localparam int RSW_PIN_DRIVE_CYC = 8;
	localparam int RSW_PIN_SAMPLE_CYC = 4;
	localparam int RSW_EXT_MIN_CYC = 16;
	localparam int RSW_PROTECT_CYC = 64;
	localparam int RSW_PRESCALE_LOG2 = 15;
	localparam logic [7:0] RSW_SERVICE_ARM = 8'h55;
	localparam logic [7:0] RSW_SERVICE_CLEAR = 8'haa;
	localparam logic [1:0] RSW_RATE_RESET = 2'h0;
	localparam int RSW_CNT_W = 13;
	localparam int RSW_SEQ_W = 12;

	typedef enum logic [1:0] {
		RSW_VEC_NORMAL = 2'h0,
		RSW_VEC_WATCHDOG = 2'h1,
		RSW_VEC_CLOCKFAIL = 2'h2
	} rsw_vector_e;

	typedef enum logic [4:0] {
		RSW_ST_POR = 5'h01,
		RSW_ST_DRIVE = 5'h02,
		RSW_ST_SETTLE = 5'h04,
		RSW_ST_WAITPIN = 5'h08,
		RSW_ST_RUN = 5'h10
	} rsw_state_e;
endpackage

// ### src/rsw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_sync (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_q;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_q <= 1'b1;
			q_o <= 1'b1;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### src/rsw_top.sv
// What this block does
// RULE1: Four reset causes; power-on and pin share normal vector, others own vectors.
// RULE2: Power-on holds core in reset 128 or 4064 cycles per build option.
// RULE3: Pin still low after power-on delay keeps core in reset until high.
// RULE4: Any reset except power-on drives the reset pin low for eight cycles, then releases.
// RULE5: Sample pin four cycles after release; low means external, high internal.
// RULE6: External source holds pin low at least 16 cycles.
// RULE7: Enabled watchdog counts freely and resets the system on timeout.
// RULE8: Watchdog enable follows disable config, taken only at system reset.
// RULE9: Special modes start with watchdog resets inhibited; writing zero enables them.
// RULE10: Tick is bus clock over 2^15, or modulus timer underflow with synth.
// RULE11: Rate select clears to zero on reset, shortest timeout.
// RULE12: Normal modes allow one rate write within 64 cycles after reset.
// RULE13: Without synth rates divide prescaled tick by 1, 4, 16, 64.
// RULE14: With synth rates divide modulus tick by 4, 16, 64, 256.
// RULE15: Timeout never short, may be one source tick long.
// RULE16: Service by writing 0x55 then 0xaa; only that order clears counter.
// RULE17: Monitor enable clears on reset; when set, clock failure resets.
// RULE18: Force bit keeps monitor on until next reset; else follows enable.
// RULE19: Every reset clears watchdog counter and service arm state.
// RULE20: Any wrong second value drops armed state; fresh arm needed.
`timescale 1ns/1ps
`default_nettype none
module rsw_top
	import rsw_pkg::*;
#(
	parameter bit LONG_POR_DELAY = 1'b1,
	parameter int POR_LONG_CYCLES = RSW_POR_LONG_CYC,
	parameter int PRESCALE_LOG2 = RSW_PRESCALE_LOG2
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Reset pin, open drain
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	// Configuration
	input wire logic special_mode_i,
	input wire logic watchdog_disable_cfg_i,
	input wire logic synth_supply_select_i,
	input wire logic modulus_timer_tick_i,
	input wire logic clock_fail_i,
	// Software writes
	input wire logic rate_wr_i,
	input wire logic [1:0] rate_wdata_i,
	input wire logic inhibit_wr_i,
	input wire logic inhibit_wdata_i,
	input wire logic monitor_enable_wr_i,
	input wire logic monitor_enable_wdata_i,
	input wire logic monitor_force_wr_i,
	input wire logic monitor_force_wdata_i,
	input wire logic service_wr_i,
	input wire logic [7:0] service_wdata_i,
	// Status
	output logic core_reset_o,
	output logic [1:0] vector_o,
	output logic [1:0] watchdog_rate_select_o,
	output logic watchdog_enabled_o,
	output logic inhibit_internal_resets_o,
	output logic monitor_enable_o,
	output logic monitor_force_on_o,
	output logic service_armed_o
);
	localparam int POR_CYC = LONG_POR_DELAY ? POR_LONG_CYCLES : RSW_POR_SHORT_CYC;

	rsw_state_e state_q;
	logic [RSW_SEQ_W-1:0] seq_cnt_q;
	logic [RSW_CNT_W-1:0] protect_cnt_q;
	logic [PRESCALE_LOG2-1:0] pre_q;
	logic pin_s, fail_s, mtick_s, mtick_d1_q;
	logic rate_written_q, sys_rst, wd_timeout, wd_tick, mon_active, wd_fire;
	logic [1:0] cause_q;

	rsw_sync u_pin (.clk_i(core_clk_i), .resetn_i(resetn_i), .d_i(rst_pin_i), .q_o(pin_s));
	rsw_sync u_fail (.clk_i(core_clk_i), .resetn_i(resetn_i), .d_i(~clock_fail_i),
		.q_o(fail_s));
	rsw_sync u_mtick (.clk_i(core_clk_i), .resetn_i(resetn_i), .d_i(modulus_timer_tick_i),
		.q_o(mtick_s));

	assign mon_active = monitor_enable_o | monitor_force_on_o; // [RULE18]
	assign wd_fire = wd_timeout && watchdog_enabled_o && !inhibit_internal_resets_o; // [RULE9]
	assign sys_rst = (state_q != RSW_ST_RUN);

	// Reset sequencer
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= RSW_ST_POR;
			seq_cnt_q <= '0;
			cause_q <= RSW_VEC_NORMAL;
		end else begin
			case (state_q)
				RSW_ST_POR: begin
					if (seq_cnt_q >= RSW_SEQ_W'(POR_CYC - 1)) begin
						seq_cnt_q <= '0;
						state_q <= RSW_ST_WAITPIN; // [RULE2]
					end else begin
						seq_cnt_q <= seq_cnt_q + 12'd1;
					end
				end
				RSW_ST_DRIVE: begin
					if (seq_cnt_q >= RSW_SEQ_W'(RSW_PIN_DRIVE_CYC - 1)) begin
						seq_cnt_q <= '0;
						state_q <= RSW_ST_SETTLE; // [RULE4]
					end else begin
						seq_cnt_q <= seq_cnt_q + 12'd1;
					end
				end
				RSW_ST_SETTLE: begin
					if (seq_cnt_q >= RSW_SEQ_W'(RSW_PIN_SAMPLE_CYC - 1)) begin
						seq_cnt_q <= '0;
						if (!pin_s) begin
							cause_q <= RSW_VEC_NORMAL; // [RULE5] [RULE6]
						end
						state_q <= RSW_ST_WAITPIN;
					end else begin
						seq_cnt_q <= seq_cnt_q + 12'd1;
					end
				end
				RSW_ST_WAITPIN: begin
					if (pin_s) begin
						state_q <= RSW_ST_RUN; // [RULE3]
					end
				end
				RSW_ST_RUN: begin
					if (mon_active && !fail_s) begin
						cause_q <= RSW_VEC_CLOCKFAIL; // [RULE17]
						state_q <= RSW_ST_DRIVE;
					end else if (wd_fire) begin
						cause_q <= RSW_VEC_WATCHDOG; // [RULE7]
						state_q <= RSW_ST_DRIVE;
					end else if (!pin_s) begin
						cause_q <= RSW_VEC_NORMAL; // [RULE1]
						state_q <= RSW_ST_DRIVE;
					end
				end
				default: state_q <= RSW_ST_POR;
			endcase
		end
	end

	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_o = (state_q == RSW_ST_DRIVE); // [RULE4]
	assign core_reset_o = sys_rst;
	assign vector_o = cause_q; // [RULE1] [RULE5]

	// Enable latched during the reset sequence only; inhibit also writable in special mode
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			watchdog_enabled_o <= 1'b0;
			inhibit_internal_resets_o <= 1'b1;
		end else if (sys_rst) begin
			watchdog_enabled_o <= !watchdog_disable_cfg_i; // [RULE8]
			inhibit_internal_resets_o <= special_mode_i; // [RULE9]
		end else if (inhibit_wr_i && special_mode_i) begin
			inhibit_internal_resets_o <= inhibit_wdata_i; // [RULE9]
		end
	end

	// Monitor control
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			monitor_enable_o <= 1'b0;
			monitor_force_on_o <= 1'b0;
		end else if (sys_rst) begin
			monitor_enable_o <= 1'b0; // [RULE17]
			monitor_force_on_o <= 1'b0;
		end else begin
			if (monitor_enable_wr_i) begin
				monitor_enable_o <= monitor_enable_wdata_i;
			end
			if (monitor_force_wr_i && (special_mode_i ||
				(!rate_written_q && protect_cnt_q < RSW_CNT_W'(RSW_PROTECT_CYC)))) begin
				monitor_force_on_o <= monitor_force_wdata_i | monitor_force_on_o; // [RULE18]
			end
		end
	end

	// Rate select, write-once window
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			watchdog_rate_select_o <= RSW_RATE_RESET;
			rate_written_q <= 1'b0;
			protect_cnt_q <= '0;
		end else if (sys_rst) begin
			watchdog_rate_select_o <= RSW_RATE_RESET; // [RULE11]
			rate_written_q <= 1'b0;
			protect_cnt_q <= '0;
		end else begin
			if (protect_cnt_q < RSW_CNT_W'(RSW_PROTECT_CYC)) begin
				protect_cnt_q <= protect_cnt_q + 13'd1;
			end
			if (rate_wr_i && (special_mode_i ||
				(!rate_written_q && protect_cnt_q < RSW_CNT_W'(RSW_PROTECT_CYC)))) begin
				watchdog_rate_select_o <= rate_wdata_i; // [RULE12]
				rate_written_q <= 1'b1;
			end
		end
	end

	// Tick source
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pre_q <= '0;
			// Matches the synchroniser's reset level, no false tick
			mtick_d1_q <= 1'b1;
		end else begin
			pre_q <= pre_q + 1'b1;
			mtick_d1_q <= mtick_s;
		end
	end

	assign wd_tick = synth_supply_select_i ? (mtick_s && !mtick_d1_q)
		: (pre_q == '1); // [RULE10]

	rsw_watchdog u_wd (
		.clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.sys_rst_i(sys_rst),
		.active_i(watchdog_enabled_o),
		.tick_i(wd_tick),
		.synth_i(synth_supply_select_i),
		.rate_i(watchdog_rate_select_o),
		.wr_i(service_wr_i),
		.wdata_i(service_wdata_i),
		.armed_o(service_armed_o),
		.timeout_o(wd_timeout),
		.count_o()
	);
endmodule
`default_nettype wire

// ### src/rsw_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_watchdog
	import rsw_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic active_i,
	input wire logic tick_i,
	input wire logic synth_i,
	input wire logic [1:0] rate_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	// Status
	output logic armed_o,
	output logic timeout_o,
	output logic [RSW_CNT_W-1:0] count_o
);
	logic [RSW_CNT_W-1:0] limit;

	// Synth tick counts x4 more per step than the prescaled tick
	always_comb begin
		case (rate_i)
			2'h0: limit = synth_i ? 13'd4 : 13'd1;
			2'h1: limit = synth_i ? 13'd16 : 13'd4;
			2'h2: limit = synth_i ? 13'd64 : 13'd16;
			default: limit = synth_i ? 13'd256 : 13'd64;
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			armed_o <= 1'b0;
		end else if (sys_rst_i) begin
			armed_o <= 1'b0; // [RULE19]
		end else if (wr_i) begin
			armed_o <= (wdata_i == RSW_SERVICE_ARM); // [RULE16] [RULE20]
		end
	end

	// One tick past the limit: the first tick may be partial, so never short
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_o <= '0;
			timeout_o <= 1'b0;
		end else if (sys_rst_i || !active_i) begin
			count_o <= '0; // [RULE19]
			timeout_o <= 1'b0;
		end else if (wr_i && armed_o && wdata_i == RSW_SERVICE_CLEAR) begin
			count_o <= '0; // [RULE16]
			timeout_o <= 1'b0;
		end else if (tick_i && !timeout_o) begin
			count_o <= count_o + 13'd1; // [RULE7]
			timeout_o <= (count_o >= limit); // [RULE13] [RULE14] [RULE15]
		end
	end
endmodule
`default_nettype wire

// ### testbench/rsw_ext_reset.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_ext_reset
	import rsw_pkg::*;
(
	// Pin and request
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic hold_i,
	output logic pin_o
);
	int cnt_q = 0;
	// Stretched so a short request still reads as external
	always @(posedge clk_i) cnt_q <= hold_i ? RSW_EXT_MIN_CYC : cnt_q - (cnt_q > 0);
	// Pull-up: a released pin reads high
	assign pin_o = !(oe_i || hold_i || cnt_q > 0);
endmodule
`default_nettype wire

// ### testbench/rsw_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_top_monitor
	import rsw_pkg::*;
(
	// Watched ports
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic rst_pin_oe_o,
	input wire logic core_reset_o,
	input wire logic special_mode_i,
	input wire logic clock_fail_i,
	input wire logic rate_wr_i,
	input wire logic service_wr_i,
	input wire logic [7:0] service_wdata_i,
	input wire logic [1:0] watchdog_rate_select_o,
	input wire logic watchdog_enabled_o,
	input wire logic monitor_enable_o,
	input wire logic monitor_force_on_o,
	input wire logic service_armed_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [6:0] run_cnt_q;
	logic rate_seen_q;
	// Write-once window rebuilt from the ports alone
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_cnt_q <= '0;
			rate_seen_q <= 1'b0;
		end else if (core_reset_o) begin
			run_cnt_q <= '0;
			rate_seen_q <= 1'b0;
		end else begin
			if (run_cnt_q < 7'(RSW_PROTECT_CYC)) begin
				run_cnt_q <= run_cnt_q + 7'd1;
			end
			if (rate_wr_i) begin
				rate_seen_q <= 1'b1;
			end
		end
	end
	sequence s_drive;
		rst_pin_oe_o [*8] ##1 !rst_pin_oe_o;
	endsequence
	sequence s_run;
		!core_reset_o ##1 !core_reset_o;
	endsequence
	chk_pin_drive: assert property ($rose(rst_pin_oe_o) |-> s_drive)
		else $error("pin drive length");
	chk_sample_hold: assert property ($fell(rst_pin_oe_o) |-> core_reset_o [*5])
		else $error("core left reset early");
	chk_reset_vals: assert property ($fell(core_reset_o) |->
		!watchdog_rate_select_o && !service_armed_o && !monitor_enable_o && !monitor_force_on_o)
		else $error("reset state");
	chk_rate_lock: assert property (!rate_wr_i ##0 s_run |->
		$stable(watchdog_rate_select_o)) else $error("rate changed");
	chk_rate_once: assert property (rate_wr_i && !core_reset_o && !special_mode_i
		&& (rate_seen_q || run_cnt_q == 7'(RSW_PROTECT_CYC)) |=> $stable(watchdog_rate_select_o))
		else $error("late rate write taken");
	chk_en_fixed: assert property (s_run |-> $stable(watchdog_enabled_o))
		else $error("enable changed");
	chk_arm_set: assert property (service_wr_i && service_wdata_i == 8'h55
		&& !core_reset_o |=> service_armed_o || core_reset_o) else $error("not armed");
	chk_arm_drop: assert property (service_wr_i && !core_reset_o
		&& service_wdata_i != 8'h55 && service_wdata_i != 8'haa |=> !service_armed_o)
		else $error("arm kept");
	chk_clk_fail: assert property ((monitor_enable_o || monitor_force_on_o)
		&& clock_fail_i && !core_reset_o |-> ##[1:8] rst_pin_oe_o)
		else $error("clock failure ignored");
endmodule
bind rsw_top rsw_top_monitor u_mon (.*);
`default_nettype wire

// ### testbench/tb_rsw_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rsw_top
	import rsw_pkg::*;
;
	localparam int POR_CYC = 20;
	localparam int PS_LG2 = 4;
	logic clk = 1'b0, rstn = 1'b0, hold = 1'b0, spec = 1'b0, cfg = 1'b1;
	logic syn = 1'b0, mt = 1'b0, cf = 1'b0;
	logic [4:0] ws = 5'h0;
	logic [7:0] wd = 8'h0;
	wire logic pin;
	logic oe, drv, core, en, inh, me, mf, arm;
	logic [1:0] vec, rate;
	int err_total = 0;
	int n_tests = 0;
	int n, k;
	rsw_top #(.POR_LONG_CYCLES(POR_CYC), .PRESCALE_LOG2(PS_LG2)) dut (
		.core_clk_i(clk), .resetn_i(rstn), .rst_pin_i(pin), .rst_pin_o(drv), .rst_pin_oe_o(oe),
		.special_mode_i(spec), .watchdog_disable_cfg_i(cfg), .synth_supply_select_i(syn),
		.modulus_timer_tick_i(mt), .clock_fail_i(cf), .rate_wr_i(ws[0]), .rate_wdata_i(wd[1:0]),
		.inhibit_wr_i(ws[1]), .inhibit_wdata_i(wd[0]), .monitor_enable_wr_i(ws[2]),
		.monitor_enable_wdata_i(wd[0]), .monitor_force_wr_i(ws[3]), .monitor_force_wdata_i(wd[0]),
		.service_wr_i(ws[4]), .service_wdata_i(wd), .core_reset_o(core), .vector_o(vec),
		.watchdog_rate_select_o(rate), .watchdog_enabled_o(en), .inhibit_internal_resets_o(inh),
		.monitor_enable_o(me), .monitor_force_on_o(mf), .service_armed_o(arm));
	rsw_ext_reset ext (.clk_i(clk), .oe_i(oe), .hold_i(hold), .pin_o(pin));
	initial forever #20 clk = ~clk;
	// Modulus timer tick every four cycles
	always begin
		repeat (2) @(posedge clk);
		mt <= ~mt;
	end
	function automatic int tick_len(input int i);
		return i < 4 ? 1 << PS_LG2 : 4;
	endfunction
	function automatic int to_len(input int i);
		return tick_len(i) * (i < 4 ? 1 : 4) << (2 * (i % 4));
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int v, input int lo, input int hi);
		n_tests++;
		if (v < lo || v > hi) begin
			err_total++;
			$display("wrong value at %0t: %h exp %h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic wr(input int s, input logic [7:0] d);
		ws[s] <= 1'b1;
		wd <= d;
		@(posedge clk);
		ws <= 5'h0;
		@(posedge clk);
	endtask
	// Bounded wait for pin drive or for core release
	task automatic wait_sig(input bit use_oe, input int lim, output int c);
		c = 0;
		while ((use_oe ? oe !== 1'b1 : core !== 1'b0) && c < lim) begin
			@(posedge clk);
			c++;
		end
		if (c >= lim) chk_rng(c, 0, lim - 1);
	endtask
	task automatic por();
		rstn <= 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		err_total++;
		stop_test();
	end
	initial begin
		k = $urandom(64);
		@(posedge clk);
		por();
		wait_sig(0, 100, n);
		chk_rng(n, POR_CYC, POR_CYC + 5);
		chk({vec, rate, me, mf, en}, 8'h0);
		k = $urandom_range(3, 1);
		wr(0, 8'(k));
		wr(0, 8'(k ^ 3));
		chk(rate, 8'(k));
		cfg <= 1'b0;
		hold <= 1'b1;
		por();
		repeat (40) @(posedge clk);
		chk(core, 8'h1);
		hold <= 1'b0;
		wait_sig(0, 40, n);
		chk({vec, en}, {RSW_VEC_NORMAL, 1'b1});
		for (int i = 0; i < 8; i++) begin
			wr(0, 8'(i % 4));
			wait_sig(1, 1200, n);
			k = to_len(i);
			chk_rng(n + 2, k, k + tick_len(i) + 6);
			syn <= i >= 3;
			wait_sig(0, 60, n);
			chk({vec, rate}, {RSW_VEC_WATCHDOG, 2'h0});
		end
		repeat (20) begin
			wr(4, RSW_SERVICE_ARM);
			wr(4, RSW_SERVICE_CLEAR);
			repeat ($urandom_range(3)) @(posedge clk);
			chk(oe, 8'h0);
		end
		wr(4, RSW_SERVICE_ARM);
		repeat (8) @(posedge clk);
		wr(4, 8'($urandom_range(8'h54)));
		chk(arm, 8'h0);
		wr(4, RSW_SERVICE_CLEAR);
		wait_sig(1, 12, n);
		wait_sig(0, 60, n);
		for (int j = 0; j < 3; j++) begin
			// Force bit shares the write-once window, so it goes before the rate
			if (j < 2) wr(2 + j, 8'h1);
			wr(0, 8'h3);
			cf <= 1'b1;
			repeat (10) @(posedge clk);
			cf <= 1'b0;
			chk(core, 8'(j < 2));
			wait_sig(0, 60, n);
			if (j < 2) chk({vec, me, mf}, {RSW_VEC_CLOCKFAIL, 2'h0});
		end
		hold <= 1'b1;
		@(posedge clk);
		hold <= 1'b0;
		wait_sig(1, 10, n);
		chk({oe, drv}, 8'h2);
		wait_sig(0, 80, n);
		chk(vec, RSW_VEC_NORMAL);
		spec <= 1'b1;
		por();
		wait_sig(0, 60, n);
		chk(inh, 8'h1);
		repeat (60) @(posedge clk);
		chk(core, 8'h0);
		wr(0, 8'h2);
		wr(0, 8'h1);
		chk(rate, 8'h1);
		wr(1, 8'h0);
		wait_sig(1, 12, n);
		stop_test();
	end
endmodule
`default_nettype wire
